// *** hw/crosscheck_regs.svh ***
`ifndef CROSSCHECK_REGS_SVH
`define CROSSCHECK_REGS_SVH

// clock and time base
`define CLK_HZ           20000000
`define CYC_PER_MS       (`CLK_HZ / 1000)
`define DISC_TIME_MS     1000
`define CMD_DISC_TIME_MS 10000
`define COMM_LOSS_MS     1000
`define OUT_CLEAR_MS     5000

// register byte offsets
`define REG_STATUS       12'h000
`define REG_ALARM        12'h004
`define REG_CYCLE        12'h008
`define REG_FADDR        12'h00C
`define REG_DIFF         12'h010

// status fields
`define ST_ALARM         0
`define ST_STOP          1
`define ST_STOP_E        2
`define ST_FAULT         3
`define ST_COMMIS        4
`define ST_ADDR_BAD      5
`define ST_OUT_CLR       28
`define ST_COMM_RUN      29

// reset values and codes
`define CYCLE_RST        8'h01
`define FADDR_RST        16'h0000
`define ALARM_MISMATCH   16'h69D2
`define KERN_STOP_D      3'h3
`define KERN_STOP_E      3'h4

`endif

// *** hw/crosscheck_pkg.sv ***
package crosscheck_pkg;

   // one channel's compared vectors
   typedef struct packed {
      logic [63:0] cmd_word;
      logic [63:0] markers;
      logic [63:0] int_out;
      logic [63:0] int_in;
      logic [63:0] ext_out;
      logic [63:0] ext_in;
   } chan_vec_s;

   // comm-loss supervision states
   typedef enum logic [1:0] {
      COMM_OK      = 2'b00,
      COMM_WAIT    = 2'b01,
      COMM_CLEARED = 2'b10
   } comm_state_e;

endpackage

// *** hw/discrepancy_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// counts while run is high, restarts from zero whenever run drops
module discrepancy_timer #(
   parameter int CNT_W = 28
) (
   input  wire logic             pclk,     // system clock
   input  wire logic             presetn,  // async reset, active low
   input  wire logic             run,      // count while high
   input  wire logic [CNT_W-1:0] limit,    // terminal count
   output logic                  expired   // level, cnt at limit
);

   logic [CNT_W-1:0] cnt_q;

   // saturate at the limit so expired stays up while run holds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (cnt_q != limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign expired = run && (cnt_q == limit);

endmodule // discrepancy_timer

`default_nettype wire

// *** hw/dual_channel_crosscheck.sv ***
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "crosscheck_regs.svh"

// What this block does
// [R1] tolerate difference 1 s, command word 10 s
// [R2] compare five vectors plus both channel settings
// [R3] mismatch raises alarm with code 27090
// [R4] stop only once commissioning flagged complete
// [R5] kernel complete when either id entry nonzero
// [R6] controller complete when its done bit is 1
// [R7] kernel mode 3 stop D, 4 stop E
// [R8] controller bit 1 stop E, 0 stop D
// [R9] settings take effect only after power-on
// [R10] input module fault clears inputs, stops
// [R11] one input state delivered to both channels
// [R12] telegram data is AND of external outputs
// [R13] at most 64 useful bits per module
// [R14] module address accepted only 1 to 65535
// [R15] bus cycle is n interpolation cycles, n>=1
// [R16] remote station configuration below 244 bytes; not checked by this block
// [R17] integrator feeds signals to both channels
// [R18] single-channel signals passed to other channel; this block passes none
// [R19] timer runs on difference, restarts on agreement
// [R20] exchange lost 1 s: 5 s, clear outputs
module dual_channel_crosscheck
   import crosscheck_pkg::*;
#(
   parameter int          CNT_W    = 28,
   parameter int          DATA_W   = 64,
   parameter [CNT_W-1:0]  DISC_CYC = CNT_W'(`DISC_TIME_MS * `CYC_PER_MS),
   parameter [CNT_W-1:0]  CMD_CYC  = CNT_W'(`CMD_DISC_TIME_MS * `CYC_PER_MS),
   parameter [CNT_W-1:0]  LOSS_CYC = CNT_W'(`COMM_LOSS_MS * `CYC_PER_MS),
   parameter [CNT_W-1:0]  CLR_CYC  = CNT_W'(`OUT_CLEAR_MS * `CYC_PER_MS)
) (
   input  wire logic              pclk,            // 20 MHz clock
   input  wire logic              presetn,         // async reset, active low
   input  wire logic              psel,            // apb select
   input  wire logic              penable,         // apb access phase
   input  wire logic              pwrite,          // apb direction
   input  wire logic [11:0]       paddr,           // apb byte address
   input  wire logic [31:0]       pwdata,          // apb write data
   output logic [31:0]            prdata,          // apb read data
   output logic                   pready,          // apb ready
   output logic                   pslverr,         // apb unmapped access
   input  wire chan_vec_s         kern_vec,        // motion_kernel vectors
   input  wire chan_vec_s         ctrl_vec,        // safe_logic controller vectors
   input  wire logic              xchg_strobe,     // one pulse per data exchange
   input  wire logic [15:0]       prot_id0,        // protected_id_range entry 0
   input  wire logic [15:0]       prot_id1,        // protected_id_range entry 1
   input  wire logic [2:0]        crosscheck_stop_select, // kernel stop mode
   input  wire logic              commissioning_done_bit, // controller done
   input  wire logic              stop_e_select_bit,      // controller stop E
   input  wire logic              ipo_tick,        // interpolation_cycle pulse
   input  wire logic              fb_in_valid,     // input module telegram
   input  wire logic [15:0]       fb_in_addr,      // its module address
   input  wire logic [DATA_W-1:0] fb_in_data,      // its useful data
   input  wire logic              fb_in_fault,     // module reports a fault
   output logic [DATA_W-1:0]      ext_safety_in,   // shared input state
   output logic                   tel_valid,       // safety_bus_cycle telegram
   output logic [15:0]            tel_addr,        // telegram module address
   output logic [DATA_W-1:0]      tel_data,        // telegram useful data
   output logic                   kern_stop_d,     // kernel stop-D response
   output logic                   kern_stop_e,     // kernel stop-E response
   output logic                   ctrl_stop_d,     // controller stop-D response
   output logic                   ctrl_stop_e,     // controller stop-E response
   output logic                   mismatch_alarm   // alarm 27090 active
);

   logic              cfg_loaded_q;
   logic              kern_commis_q, ctrl_commis_q;
   logic [2:0]        kern_mode_q;
   logic              ctrl_sel_e_q;
   logic              alarm_q, fault_q, stop_req_q;
   logic [7:0]        cycle_n_q;
   logic [15:0]       faddr_q;
   logic [7:0]        ipo_cnt_q;
   logic [31:0]       prdata_q;
   comm_state_e       comm_q;
   logic [5:0]        diff_vec;
   logic              diff_any, disc_exp, cmd_exp, loss_exp, clr_exp;
   logic              alarm_set, addr_ok, fault_ev, bus_end;
   logic              wr_en, rd_setup, mapped;
   logic [7:0]        eff_n;

   // settings compared as signals of their own
   assign diff_vec[0] = (kern_vec.ext_in  != ctrl_vec.ext_in);  // [R2]
   assign diff_vec[1] = (kern_vec.ext_out != ctrl_vec.ext_out); // [R2]
   assign diff_vec[2] = (kern_vec.int_in  != ctrl_vec.int_in);  // [R2]
   assign diff_vec[3] = (kern_vec.int_out != ctrl_vec.int_out); // [R2]
   assign diff_vec[4] = (kern_vec.markers != ctrl_vec.markers); // [R2]
   assign diff_vec[5] = (kern_commis_q != ctrl_commis_q) ||
                        ((kern_mode_q == `KERN_STOP_E) != ctrl_sel_e_q); // [R2]
   assign diff_any    = |diff_vec;

   // vectors share one 1 s window, command word its own 10 s window
   discrepancy_timer #(.CNT_W(CNT_W)) u_disc (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (diff_any),                                   // [R19]
      .limit   (DISC_CYC),                                   // [R1]
      .expired (disc_exp)
   );
   discrepancy_timer #(.CNT_W(CNT_W)) u_cmd (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (kern_vec.cmd_word != ctrl_vec.cmd_word),     // [R19]
      .limit   (CMD_CYC),                                    // [R1]
      .expired (cmd_exp)
   );
   // exchange supervision: a strobe restarts the silence count
   discrepancy_timer #(.CNT_W(CNT_W)) u_loss (
      .pclk    (pclk),
      .presetn (presetn),
      .run     ((comm_q == COMM_OK) && !xchg_strobe),        // [R20]
      .limit   (LOSS_CYC),
      .expired (loss_exp)
   );
   discrepancy_timer #(.CNT_W(CNT_W)) u_clr (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (comm_q == COMM_WAIT),                        // [R20]
      .limit   (CLR_CYC),
      .expired (clr_exp)
   );

   assign alarm_set = disc_exp || cmd_exp;                   // [R19]
   assign addr_ok   = (faddr_q != 16'h0000);                 // [R14]
   assign fault_ev  = fb_in_valid && fb_in_fault && addr_ok &&
                      (fb_in_addr == faddr_q);
   assign eff_n     = (cycle_n_q == 8'h00) ? 8'h01 : cycle_n_q; // [R15]
   assign bus_end   = ipo_tick && (ipo_cnt_q == eff_n - 8'h01);

   // settings are caught once after reset release and then frozen;
   // later changes only count after the next power-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_loaded_q  <= 1'b0;
         kern_commis_q <= 1'b0;
         ctrl_commis_q <= 1'b0;
         kern_mode_q   <= 3'h0;
         ctrl_sel_e_q  <= 1'b0;
      end else if (!cfg_loaded_q) begin                      // [R9]
         cfg_loaded_q  <= 1'b1;
         kern_commis_q <= (prot_id0 != 16'h0000) || (prot_id1 != 16'h0000); // [R5]
         ctrl_commis_q <= (commissioning_done_bit == 1'b1);  // [R6]
         kern_mode_q   <= crosscheck_stop_select;
         ctrl_sel_e_q  <= stop_e_select_bit;
      end
   end

   // apb decode: zero wait states, read data captured in setup
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr == `REG_STATUS) || (paddr == `REG_ALARM) ||
                     (paddr == `REG_CYCLE)  || (paddr == `REG_FADDR) ||
                     (paddr == `REG_DIFF);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_q;

   // sticky alarm; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_q <= 1'b0;
      end else if (alarm_set) begin
         alarm_q <= 1'b1;                                    // [R3]
      end else if (wr_en && (paddr == `REG_STATUS) && pwdata[`ST_ALARM]) begin
         alarm_q <= 1'b0;
      end
   end

   // module fault flag, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
      end else if (fault_ev) begin
         fault_q <= 1'b1;                                    // [R10]
      end else if (wr_en && (paddr == `REG_STATUS) && pwdata[`ST_FAULT]) begin
         fault_q <= 1'b0;
      end
   end

   // a stop is latched until power-on; software cannot release it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_req_q <= 1'b0;
      end else if ((alarm_set && (kern_commis_q || ctrl_commis_q)) || fault_ev) begin
         stop_req_q <= 1'b1;                                 // [R4] [R10]
      end
   end

   // per-channel response kind from each channel's own setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kern_stop_d <= 1'b0;
         kern_stop_e <= 1'b0;
         ctrl_stop_d <= 1'b0;
         ctrl_stop_e <= 1'b0;
      end else begin
         kern_stop_e <= stop_req_q && (kern_mode_q == `KERN_STOP_E);  // [R7]
         kern_stop_d <= stop_req_q && (kern_mode_q != `KERN_STOP_E);  // [R7]
         ctrl_stop_e <= stop_req_q && ctrl_sel_e_q;                   // [R8]
         ctrl_stop_d <= stop_req_q && !ctrl_sel_e_q;                  // [R8]
      end
   end

   assign mismatch_alarm = alarm_q;                          // [R3]

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_n_q <= `CYCLE_RST;
         faddr_q   <= `FADDR_RST;
      end else if (wr_en) begin
         if (paddr == `REG_CYCLE) begin
            cycle_n_q <= pwdata[7:0];
         end
         if (paddr == `REG_FADDR) begin
            faddr_q <= pwdata[15:0];                         // [R14]
         end
      end
   end

   // read mux, latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_q <= 32'h00000000;
         unique case (paddr)
            `REG_STATUS: begin
               prdata_q[`ST_ALARM]    <= alarm_q;
               prdata_q[`ST_STOP]     <= stop_req_q;
               prdata_q[`ST_STOP_E]   <= kern_stop_e;
               prdata_q[`ST_FAULT]    <= fault_q;
               prdata_q[`ST_COMMIS]   <= kern_commis_q || ctrl_commis_q;
               prdata_q[`ST_ADDR_BAD] <= !addr_ok;
               prdata_q[`ST_OUT_CLR]  <= (comm_q == COMM_CLEARED);
               prdata_q[`ST_COMM_RUN] <= (comm_q != COMM_OK);   // [R20]
            end
            `REG_ALARM: prdata_q[15:0] <= alarm_q ? `ALARM_MISMATCH : 16'h0000; // [R3]
            `REG_CYCLE: prdata_q[7:0]  <= cycle_n_q;
            `REG_FADDR: prdata_q[15:0] <= faddr_q;
            `REG_DIFF:  prdata_q[6:0]  <= {kern_vec.cmd_word != ctrl_vec.cmd_word, diff_vec};
            default:    prdata_q       <= 32'h00000000;
         endcase
      end
   end

   // exchange loss: start 5 s warning, then clear outputs until power-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_q <= COMM_OK;
      end else begin
         unique case (comm_q)
            COMM_OK:      if (loss_exp) comm_q <= COMM_WAIT;    // [R20]
            COMM_WAIT:    if (clr_exp) comm_q <= COMM_CLEARED;  // [R20]
            COMM_CLEARED: comm_q <= COMM_CLEARED;
            default:      comm_q <= COMM_CLEARED;
         endcase
      end
   end

   // one input state for both channels; a fault clears the bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_safety_in <= '0;
      end else if (fb_in_valid && addr_ok && (fb_in_addr == faddr_q)) begin
         ext_safety_in <= fb_in_fault ? '0 : fb_in_data;     // [R10] [R11]
      end
   end

   // interpolation ticks per bus cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ipo_cnt_q <= 8'h00;
      end else if (ipo_tick) begin
         ipo_cnt_q <= bus_end ? 8'h00 : ipo_cnt_q + 8'h01;   // [R15]
      end
   end

   // output telegram; width capped at 64 useful bits by DATA_W
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tel_valid <= 1'b0;
         tel_addr  <= 16'h0000;
         tel_data  <= '0;
      end else begin
         tel_valid <= bus_end && addr_ok;                    // [R14] [R15]
         if (bus_end && addr_ok) begin
            tel_addr <= faddr_q;
            tel_data <= (comm_q == COMM_CLEARED) ? '0 :
                        DATA_W'(kern_vec.ext_out & ctrl_vec.ext_out); // [R12] [R13] [R20]
         end else if (comm_q == COMM_CLEARED) begin
            tel_data <= '0;                                  // [R20]
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_disc_alarm:    assert property (disc_exp |=> alarm_q)           // [R1] [R19]
      else $error("discrepancy expiry did not raise alarm");
   a_cmd_alarm:     assert property (cmd_exp |=> alarm_q)            // [R1]
      else $error("command word expiry did not raise alarm");
   a_timer_restart: assert property (!diff_any |=> !disc_exp)        // [R19]
      else $error("discrepancy timer not restarted on agreement");
   a_alarm_code:    assert property (alarm_q && rd_setup && paddr == `REG_ALARM
                                     |=> prdata[15:0] == 16'h69D2)   // [R3]
      else $error("alarm code readback wrong");
   a_stop_gate:     assert property ($rose(stop_req_q) |->
                       $past(fault_ev) || ($past(alarm_set) &&
                       ($past(kern_commis_q) || $past(ctrl_commis_q)))) // [R4]
      else $error("stop without commissioning or fault");
   a_kern_mode:     assert property (stop_req_q && kern_mode_q == `KERN_STOP_D
                                     |=> kern_stop_d && !kern_stop_e) // [R7]
      else $error("kernel mode 3 did not select stop D");
   a_ctrl_select:   assert property (stop_req_q |=> ctrl_stop_e == ctrl_sel_e_q
                                     && ctrl_stop_d == !ctrl_sel_e_q) // [R8]
      else $error("controller stop selection wrong");
   a_cfg_frozen:    assert property (cfg_loaded_q |=> $stable(kern_mode_q)
                                     && $stable(ctrl_sel_e_q))       // [R9]
      else $error("settings changed before power-on");
   a_fault_clear:   assert property (fault_ev |=> ext_safety_in == '0
                                     && stop_req_q)                  // [R10]
      else $error("module fault did not clear inputs and stop");
   a_tel_and:       assert property (bus_end && addr_ok && comm_q != COMM_CLEARED
                       |=> tel_valid && tel_data ==
                       DATA_W'($past(kern_vec.ext_out) & $past(ctrl_vec.ext_out))) // [R12]
      else $error("telegram data is not the AND of outputs");
   a_tel_addr:      assert property (tel_valid |-> tel_addr != 16'h0000) // [R14]
      else $error("telegram sent to address zero");
   a_out_cleared:   assert property (comm_q == COMM_CLEARED |=> tel_data == '0) // [R20]
      else $error("outputs not cleared after exchange loss");

   c_alarm:   cover property ($rose(alarm_q));
   c_stop_e:  cover property ($rose(kern_stop_e));
   c_cleared: cover property (comm_q == COMM_WAIT ##1 comm_q == COMM_CLEARED);
   c_tel:     cover property (tel_valid ##1 !tel_valid);

endmodule // dual_channel_crosscheck

`default_nettype wire

// *** tb/peer_channel_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// far-side channel: mirrors the kernel vectors, optionally with injected faults
module peer_channel_model
   import crosscheck_pkg::*;
(
   input  wire logic      pclk,        // system clock
   input  wire logic      presetn,     // async reset, active low
   input  wire chan_vec_s ref_vec,     // vectors fed by the integrator
   input  wire chan_vec_s skew,        // bits this channel gets wrong
   input  wire logic      xchg_en,     // exchange alive
   output var chan_vec_s  ctrl_vec,    // controller channel vectors
   output logic           xchg_strobe  // exchange pulse
);
   logic [3:0] cnt_q;

   // both channels see the same signals unless a scenario injects skew
   assign ctrl_vec = ref_vec ^ skew;

   // exchange every 16 cycles, inside the loss window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q       <= 4'h0;
         xchg_strobe <= 1'b0;
      end else begin
         cnt_q       <= cnt_q + 4'h1;
         xchg_strobe <= xchg_en && (cnt_q == 4'h7);
      end
   end
endmodule // peer_channel_model

`default_nettype wire

// *** tb/dual_channel_crosscheck_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module dual_channel_crosscheck_bench;
   import crosscheck_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xchg_en, xchg_strobe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [15:0] prot_id0, prot_id1, fb_addr, tel_addr;
   logic [2:0]  stop_sel;
   logic        done_bit, se_bit, interpolation_cycle, fb_valid, fb_fault, tel_valid, err_q, seen;
   logic        kd, ke, cd, ce, alarm;
   logic [63:0] fb_data, ext_in, tel_data, got;
   chan_vec_s   kern_vec, ctrl_vec, skew;
   int          n_errors, check_count, cycles;

   dual_channel_crosscheck #(.DISC_CYC(28'd20), .CMD_CYC(28'd200), .LOSS_CYC(28'd30),
      .CLR_CYC(28'd50)) i_dual_channel_crosscheck (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .kern_vec(kern_vec),
      .ctrl_vec(ctrl_vec), .xchg_strobe(xchg_strobe), .prot_id0(prot_id0),
      .prot_id1(prot_id1), .crosscheck_stop_select(stop_sel),
      .commissioning_done_bit(done_bit), .stop_e_select_bit(se_bit), .ipo_tick(interpolation_cycle),
      .fb_in_valid(fb_valid), .fb_in_addr(fb_addr), .fb_in_data(fb_data),
      .fb_in_fault(fb_fault), .ext_safety_in(ext_in), .tel_valid(tel_valid),
      .tel_addr(tel_addr), .tel_data(tel_data), .kern_stop_d(kd), .kern_stop_e(ke),
      .ctrl_stop_d(cd), .ctrl_stop_e(ce), .mismatch_alarm(alarm));

   peer_channel_model i_peer_channel_model (.pclk(pclk), .presetn(presetn),
      .ref_vec(kern_vec), .skew(skew), .xchg_en(xchg_en), .ctrl_vec(ctrl_vec),
      .xchg_strobe(xchg_strobe));

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard, sized well above the whole run
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("CHECK FAILED watchdog expected finish seen timeout");
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; the wait for pready is cut only by the watchdog
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // ends at a falling edge so registered outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   task automatic tick();
      @(posedge pclk) interpolation_cycle <= 1'b1;
      @(posedge pclk) interpolation_cycle <= 1'b0;
   endtask

   task automatic wait_tel();
      seen = 1'b0;
      repeat (12) begin
         @(negedge pclk);
         if (tel_valid === 1'b1) begin
            seen = 1'b1;
            got = tel_data;
         end
      end
   endtask

   // settings only count at the first edge after reset release
   task automatic setup(input logic [15:0] p1, input logic [2:0] s, input logic d, e);
      @(posedge pclk);
      presetn <= 1'b0; prot_id1 <= p1; stop_sel <= s; done_bit <= d; se_bit <= e;
      cyc(20);
      @(posedge pclk) presetn <= 1'b1;
      cyc(2);
   endtask

   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0); chk("status", 64'h20, rd_q);
      apb(1'b0, 12'h008, 32'h0); chk("cycle", 64'h1, rd_q);
      apb(1'b0, 12'h00C, 32'h0); chk("faddr", 64'h0, rd_q);
      apb(1'b0, 12'h020, 32'h0); chk("unmapped", 64'h1, {63'h0, err_q});
   endtask

   task automatic t_window();
      @(posedge pclk) skew.ext_in <= 64'h1;
      cyc(15);
      @(posedge pclk) skew.ext_in <= 64'h0;
      cyc(3); chk("short diff", 64'h0, {63'h0, alarm});
      @(posedge pclk) skew.ext_in <= 64'h1;
      cyc(30); chk("alarm", 64'h1, {63'h0, alarm});
      chk("no stop", 64'h0, {60'h0, kd, ke, cd, ce});
      apb(1'b0, 12'h010, 32'h0); chk("diff", 64'h1, rd_q);
      apb(1'b0, 12'h004, 32'h0); chk("alarm code", 64'h69D2, rd_q);
      @(posedge pclk) skew.ext_in <= 64'h0;
      apb(1'b1, 12'h000, 32'h1);
      @(posedge pclk) skew.cmd_word <= 64'h1;
      cyc(150); chk("cmd tolerated", 64'h0, {63'h0, alarm});
      cyc(80); chk("cmd alarm", 64'h1, {63'h0, alarm});
      @(posedge pclk) skew.cmd_word <= 64'h0;
      apb(1'b1, 12'h000, 32'h1);
   endtask

   task automatic t_tel();
      tick(); wait_tel(); chk("addr 0 off", 64'h0, {63'h0, seen});
      apb(1'b1, 12'h00C, 32'h5);
      apb(1'b1, 12'h008, 32'h2);
      // skew drops kernel bits too, so a one-sided telegram is caught
      @(posedge pclk) skew.ext_out <= 64'h0000FFFF_000000F0;
      tick(); wait_tel(); chk("first tick", 64'h0, {63'h0, seen});
      tick(); wait_tel(); chk("second tick", 64'h1, {63'h0, seen});
      chk("tel data", kern_vec.ext_out & (kern_vec.ext_out ^ skew.ext_out), got);
      chk("tel addr", 64'h5, {48'h0, tel_addr});
   endtask

   // the modelled station holds input modules at addresses 5 and 6; module 5 uses all 64 useful bits, the per-module limit
   task automatic t_fb();
      @(posedge pclk); fb_valid <= 1'b1; fb_addr <= 16'h0005; fb_data <= 64'hA5C3_0FF0_1234_8001;
      @(posedge pclk); fb_addr <= 16'h0006; fb_data <= 64'h1;
      @(posedge pclk) fb_valid <= 1'b0;
      cyc(1); chk("shared input", 64'hA5C3_0FF0_1234_8001, ext_in);
      @(posedge pclk); fb_valid <= 1'b1; fb_addr <= 16'h0005; fb_fault <= 1'b1;
      @(posedge pclk) fb_valid <= 1'b0;
      cyc(4); chk("fault clears", 64'h0, ext_in);
      chk("fault stop", 64'hA, {60'h0, kd, ke, cd, ce});
      @(posedge pclk) fb_fault <= 1'b0;
   endtask

   task automatic t_loss();
      @(posedge pclk) xchg_en <= 1'b0;
      cyc(45);
      apb(1'b0, 12'h000, 32'h0); chk("loss wait", 64'h2, {62'h0, rd_q[29:28]});
      cyc(60);
      apb(1'b0, 12'h000, 32'h0); chk("loss clear", 64'h3, {62'h0, rd_q[29:28]});
      tick(); tick(); wait_tel(); chk("outputs cleared", 64'h0, got);
      @(posedge pclk) xchg_en <= 1'b1;
   endtask

   task automatic t_stop(input logic [15:0] p1, input logic [2:0] s, input logic d, e,
         input logic [3:0] exp);
      setup(p1, s, d, e);
      @(posedge pclk); stop_sel <= (s == 3'h4) ? 3'h3 : 3'h4; se_bit <= ~e;
      skew.ext_in <= 64'h1;
      cyc(30); chk("stop kind", {60'h0, exp}, {60'h0, kd, ke, cd, ce});
      apb(1'b0, 12'h000, 32'h0); chk("commissioned", 64'h1, {63'h0, rd_q[4]});
      @(posedge pclk) skew.ext_in <= 64'h0;
   endtask

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; xchg_en = 1'b1; prot_id0 = 16'h0000; prot_id1 = 16'h0000;
      stop_sel = 3'h0; done_bit = 1'b0; se_bit = 1'b0; interpolation_cycle = 1'b0; fb_valid = 1'b0;
      fb_addr = 16'h0000; fb_data = 64'h0; fb_fault = 1'b0; skew = '0;
      kern_vec = {64'h0, 64'h0, 64'h0, 64'h0, 64'hFFFF0000_F0F0F0F0, 64'h0};
      n_errors = 0; check_count = 0; cycles = 0;
      setup(16'h0000, 3'h0, 1'b0, 1'b0);
      t_regs();
      t_window();
      t_tel();
      t_fb();
      t_loss();
      t_stop(16'h0001, 3'h4, 1'b0, 1'b0, 4'b0110);
      t_stop(16'h0000, 3'h3, 1'b1, 1'b1, 4'b1001);
      tally_and_finish();
   end
endmodule // dual_channel_crosscheck_bench

`default_nettype wire
